//--- inc/wdog_pkg.sv
// Constants for the host watchdog power cycler.
// Assumes a 100 MHz clock; all times counted in seconds from a tick.
package wdog_pkg;

	// ****************************************
	// Time base
	// ****************************************
	localparam int unsigned CLOCK_HZ     = 100_000_000;
	localparam int unsigned TICK_HZ      = 1;
	localparam int unsigned TICK_CYCLES  = CLOCK_HZ / TICK_HZ;

	// ****************************************
	// Sequence times, in seconds, attempt limit and counter widths
	// ****************************************
	localparam int unsigned LOSS_S       = 1;
	localparam int unsigned HOLD_S       = 10;
	localparam int unsigned OFF_S        = 10;
	localparam int unsigned IGNORE_S     = 60;
	localparam int unsigned MAX_TRIES    = 3;

	localparam int unsigned SEC_W        = 7;
	localparam int unsigned TRY_W        = 2;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [5:0] {
		ST_WATCH  = 6'h01,
		ST_HOLD   = 6'h02,
		ST_OFF    = 6'h04,
		ST_IGNORE = 6'h08,
		ST_ALARM  = 6'h10,
		ST_START  = 6'h20
	} wd_state_t;

endpackage

//--- rtl/strobe_detect.sv
// Synchroniser and edge detector for the printer port strobe.
// Assumes the strobe pin is asynchronous to clock and active low.
`timescale 1ns/1ps
module strobe_detect
	import wdog_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Pin
	input  wire logic strobe_n,
	// Event
	output logic      char_seen
);

	logic       sync_a;
	logic       sync_b;
	logic       last;
	logic       next_last;

	always_comb begin
		next_last = sync_b;
	end

	// Only sync_b and last are looked at beyond the first stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			last   <= 1'b1;
		end else begin
			sync_a <= strobe_n;
			sync_b <= sync_a;
			last   <= next_last;
		end
	end

	// Falling edge of strobe marks one character
	assign char_seen = last & ~sync_b;

endmodule

//--- rtl/host_watchdog.sv
// Host watchdog power cycler: watches printer port strobes, cycles host power.
// Assumes one 100 MHz clock and a host power switch driven by host_power_on.
`timescale 1ns/1ps
module host_watchdog
	import wdog_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
)(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Printer port
	input  wire logic              strobe_n,
	// Power and status
	output logic                   host_power_on,
	output logic                   in_reset_seq,
	output logic                   alarm,
	output logic [TRY_W-1:0]       attempts
);

	// ****************************************
	// Port watch
	// ****************************************
	logic char_seen;

	strobe_detect u_det (
		.clock     (clock),
		.rst       (rst),
		.strobe_n  (strobe_n),
		.char_seen (char_seen)
	);

	// ****************************************
	// Second tick
	// ****************************************
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic        tick;
	logic        restart;

	always_comb begin
		tick          = (tick_cnt == TICK_LEN - 1);
		next_tick_cnt = (tick || restart) ? 32'h0 : tick_cnt + 32'h1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= next_tick_cnt;
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	wd_state_t         state;
	wd_state_t         next_state;
	logic [SEC_W-1:0]  secs;
	logic [SEC_W-1:0]  next_secs;
	logic [TRY_W-1:0]  next_attempts;
	logic              next_power;

	always_comb begin
		next_state    = state;
		next_secs     = secs;
		next_attempts = attempts;
		next_power    = host_power_on;
		restart       = 1'b0;
		unique case (state)
			ST_START: begin
				next_state = ST_WATCH;
				restart    = 1'b1;
				next_secs  = '0;
			end
			ST_WATCH: begin
				if (char_seen) begin
					restart       = 1'b1;
					next_secs     = '0;
					next_attempts = '0;
				end else if (tick) begin
					if (secs == SEC_W'(LOSS_S - 1)) begin
						next_secs = '0;
						if (attempts == TRY_W'(MAX_TRIES)) begin
							next_state = ST_ALARM;
						end else begin
							next_state = ST_HOLD;
						end
					end else begin
						next_secs = secs + SEC_W'(1);
					end
				end
			end
			ST_HOLD: begin
				// operator pause
				// Characters are refused here; only a full cycle proves recovery
				if (tick) begin
					if (secs == SEC_W'(HOLD_S - 1)) begin
						next_secs     = '0;
						next_state    = ST_OFF;
						next_power    = 1'b0;
						next_attempts = attempts + TRY_W'(1);
					end else begin
						next_secs = secs + SEC_W'(1);
					end
				end
			end
			ST_OFF: begin
				if (tick) begin
					if (secs == SEC_W'(OFF_S - 1)) begin
						next_secs  = '0;
						next_state = ST_IGNORE;
						next_power = 1'b1;
					end else begin
						next_secs = secs + SEC_W'(1);
					end
				end
			end
			ST_IGNORE: begin
				if (tick) begin
					if (secs == SEC_W'(IGNORE_S - 1)) begin
						next_secs  = '0;
						next_state = ST_WATCH;
						restart    = 1'b1;
					end else begin
						next_secs = secs + SEC_W'(1);
					end
				end
			end
			ST_ALARM: begin
				// Stays until reset; host power left on for manual recovery
				next_power = 1'b1;
			end
			default: begin
				next_state = ST_START;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state         <= ST_START;
			secs          <= '0;
			attempts      <= '0;
			host_power_on <= 1'b1;
		end else begin
			state         <= next_state;
			secs          <= next_secs;
			attempts      <= next_attempts;
			host_power_on <= next_power;
		end
	end

	assign in_reset_seq = (state == ST_HOLD) || (state == ST_OFF) || (state == ST_IGNORE);
	assign alarm        = (state == ST_ALARM);

	// ****************************************
	// Checks
	// ****************************************
	a_loss_starts_hold: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WATCH && tick && !char_seen && attempts != TRY_W'(MAX_TRIES))
		|=> state == ST_HOLD)
		else $error("loss did not start sequence");

	a_hold_keeps_power: assert property (@(posedge clock) disable iff (rst)
		state == ST_HOLD |-> host_power_on)
		else $error("power cut during hold");

	a_off_no_power: assert property (@(posedge clock) disable iff (rst)
		state == ST_OFF |-> !host_power_on)
		else $error("power on during off");

	a_power_back_ignore: assert property (@(posedge clock) disable iff (rst)
		$rose(host_power_on) |-> state == ST_IGNORE && secs == '0)
		else $error("power restored outside sequence");

	a_ignore_no_clear: assert property (@(posedge clock) disable iff (rst)
		(state == ST_IGNORE && char_seen) |=> $stable(attempts))
		else $error("char counted while ignoring");

	a_third_alarm: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WATCH && tick && !char_seen && attempts == TRY_W'(MAX_TRIES))
		|=> alarm)
		else $error("no alarm after third attempt");

	a_alarm_sticks: assert property (@(posedge clock) disable iff (rst)
		alarm |=> alarm)
		else $error("alarm left");

	a_char_clears: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WATCH && char_seen) |=> attempts == '0 && state == ST_WATCH)
		else $error("char did not clear count");

	a_count_bound: assert property (@(posedge clock) disable iff (rst)
		state == ST_HOLD |-> attempts != TRY_W'(MAX_TRIES))
		else $error("attempt count overflow");

	a_hold_refuses: assert property (@(posedge clock) disable iff (rst)
		(state == ST_HOLD && char_seen && !tick)
		|=> state == ST_HOLD && $stable(attempts))
		else $error("char accepted during hold");

	a_ignore_power_on: assert property (@(posedge clock) disable iff (rst)
		state == ST_IGNORE |-> host_power_on)
		else $error("power off during ignore");

	a_char_restarts: assert property (@(posedge clock) disable iff (rst)
		(state == ST_WATCH && char_seen) |=> tick_cnt == 32'h0)
		else $error("char did not restart window");

endmodule

//--- verif/host_port_model.sv
// Host side of the printer port: sends a hold-off character on a timer.
// Assumes the bench clock; the spacing is given in clock cycles.
`timescale 1ns/1ps
module host_port_model #(
	parameter int HALF = 10
)(
	// Clock and control
	input  wire logic clock,
	input  wire logic alive,
	// Pin
	output logic      strobe_n
);
	int cnt = 0;
	initial strobe_n = 1'b1;
	// strobe each half second
	// Low three cycles, so the pulse outlasts the pin synchroniser
	always @(negedge clock) begin
		cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
		strobe_n <= !(alive && cnt < 3);
	end
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the host watchdog power cycler.
// Assumes a short second (T cycles) so a full power cycle stays brief.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top
	import wdog_pkg::*;
;
	// ****************************************
	// Harness
	// ****************************************
	localparam int T = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic alive = 1'b0;
	logic strobe_n;
	logic host_power_on;
	logic in_reset_seq;
	logic alarm;
	logic [TRY_W-1:0] attempts;
	int fails = 0;
	int checks = 0;

	initial forever #5 clock = ~clock;
	host_port_model #(.HALF(T / 2)) host_port_model_inst (
		.clock(clock), .alive(alive), .strobe_n(strobe_n));
	host_watchdog #(.TICK_LEN(T)) host_watchdog_inst (
		.clock(clock), .rst(rst), .strobe_n(strobe_n),
		.host_power_on(host_power_on), .in_reset_seq(in_reset_seq),
		.alarm(alarm), .attempts(attempts));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic close_out;
		if (fails == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	function automatic logic sig(int k);
		case (k)
			0: return host_power_on;
			1: return in_reset_seq;
			default: return alarm;
		endcase
	endfunction

	// Cycles until the chosen output reaches v, within [lo, hi]
	task automatic span(input int k, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (sig(k) !== v && n <= hi) begin
			@(negedge clock);
			n++;
		end
		`CHK("span", 1'b1, (n >= lo && n <= hi))
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_vals;
		`CHK("host_power_on", 1'b1, host_power_on)
		`CHK("in_reset_seq", 1'b0, in_reset_seq)
		`CHK("alarm", 1'b0, alarm)
		`CHK("attempts", 2'h0, attempts)
	endtask

	// Host alive for ten seconds: no sequence may start
	task automatic t_alive;
		alive <= 1'b1;
		repeat (10 * T) begin
			@(negedge clock);
			`CHK("in_reset_seq", 1'b0, in_reset_seq)
		end
	endtask

	// One full attempt; tick phase may shorten each phase by one tick
	task automatic t_attempt(input logic [TRY_W-1:0] want, input logic revive);
		span(1, 1'b1, T / 2 + 1, T + 5);
		// With revive set, the host strobes again during the pause; the sequence must go on
		alive <= revive;
		span(0, 1'b0, 9 * T + 1, 10 * T + 5);
		alive <= 1'b0;
		`CHK("attempts", want, attempts)
		`CHK("in_reset_seq", 1'b1, in_reset_seq)
		span(0, 1'b1, 9 * T + 1, 10 * T + 5);
		alive <= revive;
		span(1, 1'b0, 59 * T + 1, 60 * T + 5);
	endtask

	task automatic t_resume;
		repeat (2 * T) @(negedge clock);
		`CHK("attempts", 2'h0, attempts)
		`CHK("in_reset_seq", 1'b0, in_reset_seq)
	endtask

	task automatic t_alarm;
		span(2, 1'b1, T / 2 + 1, T + 5);
		`CHK("host_power_on", 1'b1, host_power_on)
		`CHK("in_reset_seq", 1'b0, in_reset_seq)
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(negedge clock);
		rst = 1'b0;
		t_reset_vals();
		t_alive();
		alive <= 1'b0;
		t_attempt(2'h1, 1'b1);
		t_resume();
		alive <= 1'b0;
		t_attempt(2'h1, 1'b0);
		t_attempt(2'h2, 1'b0);
		t_attempt(2'h3, 1'b0);
		t_alarm();
		close_out();
	end

	// Whole run is near 340 seconds of T cycles
	initial begin
		repeat (1000 * T) @(posedge clock);
		fails++;
		close_out();
	end
endmodule
